// File: hdl/fpcc_console.sv
/*
 * Front panel console controller: keyswitch and mode decode, debounced
 * START / MASTER CLEAR / DATA CLEAR, examine and deposit sequencer,
 * indicator multiplexer, sense switch latch and programmed I/O, APB slave.
 * Assumes the CPU core honours the run, step, access and clear handshakes.
 */
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/100ps
module fpcc_console #(
    parameter int unsigned DEB_CYCLES = fpcc_pkg::DEBOUNCE_CYC
) (
    input  wire logic               i_core_clk,     // Core clock, 20 MHz
    input  wire logic               i_arst_n,       // Async reset, active low
    input  wire logic [1:0]         i_key,          // Keyswitch position code
    input  wire logic [2:0]         i_mode,         // Rotary mode switch code
    input  wire logic               i_start_raw,    // START contact
    input  wire logic               i_mclr_raw,     // MASTER CLEAR contact
    input  wire logic               i_dclr_raw,     // DATA CLEAR contact
    input  wire logic               i_addr_sel,     // 1: address view, 0: data view
    input  wire logic [15:0]        i_sw_up,        // Latched-up toggle positions
    input  wire logic [15:0]        i_sw_down,      // Momentary-down toggle contacts
    input  wire logic               i_large_model,  // Extended addressing present
    input  wire logic               i_seg_enabled,  // Segmentation active
    input  wire logic [15:0]        i_bma,          // Live memory address bus
    input  wire logic               i_halt_instr,   // Halt instruction executed
    input  wire logic               i_step_done,    // Single step finished
    input  wire logic [15:0]        i_next_pc,      // Next instruction address
    input  wire logic [15:0]        i_next_instr,   // Contents at next address
    input  wire logic               i_acc_ack,      // Panel access finished
    input  wire logic [15:0]        i_acc_rdata,    // Panel access read data
    input  wire fpcc_pkg::fpcc_io_t i_io,           // Programmed I/O command
    output logic [15:0]             o_io_rdata,     // Programmed input data
    output logic                    o_io_ack,       // Programmed I/O answer pulse
    output logic [15:0]             o_sense_sw,     // Sense switches for skips
    output logic                    o_cpu_run,      // CPU clock may run
    output logic                    o_step,         // Single step pulse
    output logic                    o_mclr,         // Master clear pulse
    output logic [15:0]             o_mclr_pc,      // PC value on master clear
    output logic                    o_xfer_block,   // Block interrupts and transfers
    output logic                    o_apl_enable,   // Automatic program load enable
    output logic                    o_acc_req,      // Panel access request
    output fpcc_pkg::fpcc_acc_t     o_acc,          // Panel access descriptor
    output logic                    o_halt_lamp,    // Halt lamp
    output logic [15:0]             o_display,      // Indicator lamps
    input  wire logic               psel,           // APB select
    input  wire logic               penable,        // APB enable
    input  wire logic               pwrite,         // APB direction
    input  wire logic [11:0]        paddr,          // APB byte address
    input  wire logic [31:0]        pwdata,         // APB write data
    output logic [31:0]             prdata,         // APB read data
    output logic                    pready,         // APB ready
    output logic                    pslverr         // APB error
);
    import fpcc_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_STEP} fpcc_st_t;

    fpcc_st_t         st_q;
    logic [2:0]       mode_q;
    logic             run_q;
    logic             run_was_q;
    logic             step_q;
    logic             mclr_q;
    logic [15:0]      addr_disp_q;
    logic [15:0]      data_disp_q;
    logic [15:0]      ind_q;
    logic [15:0]      sense_q;
    logic [15:0]      disp_q;
    logic [15:0]      io_rdata_q;
    logic             io_ack_q;
    logic             ctrl_lock_q;
    logic [31:0]      prdata_q;
    logic             perr_q;
    fpcc_acc_t        acc_q;
    logic [BTN_N-1:0] btn_raw;
    logic [BTN_N-1:0] stable_q;
    logic [BTN_N-1:0] press_q;
    logic             panel_live;
    logic             run_like;
    logic             start_go;
    logic             mclr_go;
    logic             entry_ok;
    logic             next_mode;
    logic             store_mode;
    logic             fetch_mode;
    logic [15:0]      target;

    // ************************************************************
    // Button debounce
    // ************************************************************
    assign btn_raw = {i_dclr_raw, i_mclr_raw, i_start_raw};

    for (genvar b = 0; b < BTN_N; b++) begin : g_deb
        logic [DEB_W-1:0] cnt_q;
        always_ff @(posedge i_core_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                cnt_q       <= '0;
                stable_q[b] <= 1'b0;
                press_q[b]  <= 1'b0;
            end else begin
                press_q[b] <= 1'b0;
                if (btn_raw[b] == stable_q[b]) begin
                    cnt_q <= '0;
                end else if (cnt_q == DEB_W'(DEB_CYCLES - 1)) begin
                    cnt_q       <= '0;
                    stable_q[b] <= btn_raw[b];
                    press_q[b]  <= btn_raw[b];
                end else begin
                    cnt_q <= cnt_q + DEB_W'(1);
                end
            end
        end
    end

    // ************************************************************
    // Mode decode
    // ************************************************************
    assign panel_live = (i_key == KEY_ON) && !ctrl_lock_q;
    assign run_like   = (mode_q == MODE_RUN) || (mode_q == MODE_LOAD);
    assign start_go   = press_q[BTN_START] && panel_live && st_q == ST_IDLE;
    assign mclr_go    = press_q[BTN_MCLR] && panel_live && !run_like;
    assign entry_ok   = panel_live && !run_like && st_q == ST_IDLE;
    assign next_mode  = (mode_q == MODE_FETCH_NEXT) || (mode_q == MODE_STORE_NEXT);
    assign store_mode = (mode_q == MODE_STORE) || (mode_q == MODE_STORE_NEXT);
    assign fetch_mode = (mode_q == MODE_FETCH) || (mode_q == MODE_FETCH_NEXT);
    assign target     = next_mode ? addr_disp_q + ADDR_STEP : addr_disp_q;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_q <= MODE_STOP;
        end else if (panel_live) begin
            mode_q <= i_mode;
        end
    end

    // ************************************************************
    // Run state and master clear
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_q     <= 1'b0;
            run_was_q <= 1'b0;
            mclr_q    <= 1'b0;
        end else begin
            run_was_q <= run_q;
            mclr_q    <= mclr_go;
            if (i_key == KEY_OFF || i_halt_instr || !run_like) begin
                run_q <= 1'b0;
            end else if (start_go) begin
                run_q <= 1'b1;
            end
        end
    end

    assign o_cpu_run    = run_q;
    assign o_mclr       = mclr_q;
    assign o_mclr_pc    = MCLR_PC;
    assign o_halt_lamp  = !run_q;
    assign o_xfer_block = !run_like;
    assign o_apl_enable = mode_q == MODE_LOAD;

    // ************************************************************
    // Examine / deposit / step sequencer
    // ************************************************************
    function automatic fpcc_acc_t build_acc(input logic [15:0] a,
                                            input logic [15:0] sw,
                                            input logic        wr,
                                            input logic [15:0] wd);
        fpcc_acc_t r;
        r         = '0;
        r.write   = wr;
        r.wdata   = wd;
        r.addr    = {6'h00, a};
        if (i_large_model && sw[SW_SPACE]) begin
            r.reg_space = 1'b1;
            r.half_hi   = sw[SW_HALF];
            if (sw[SW_SET]) begin
                r.addr = {15'h0000, sw[6:0]};
            end else begin
                r.current_register_set  = 1'b1;
                r.addr = {17'h00000, sw[4:0]};
            end
        end else if (i_large_model && sw[SW_HALF]) begin
            r.addr = {sw[5:0], a};
        end else if (i_large_model && i_seg_enabled) begin
            r.mapped  = 1'b1;
            r.segment = sw[11:0];
        end
        return r;
    endfunction

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q   <= ST_IDLE;
            step_q <= 1'b0;
            acc_q  <= '0;
        end else begin
            step_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (start_go && mode_q == MODE_STOP) begin
                        step_q <= 1'b1;
                        st_q   <= ST_STEP;
                    end else if (start_go && (store_mode || fetch_mode)) begin
                        acc_q  <= build_acc(target, sense_q, store_mode,
                                            data_disp_q);
                        st_q   <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    if (i_acc_ack) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_STEP: begin
                    if (i_step_done) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign o_acc_req = st_q == ST_ACCESS;
    assign o_acc     = acc_q;
    assign o_step    = step_q;

    // ************************************************************
    // Address and data displays
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            addr_disp_q <= '0;
            data_disp_q <= '0;
        end else if (st_q == ST_ACCESS && i_acc_ack && !acc_q.write) begin
            data_disp_q <= i_acc_rdata;
        end else if ((st_q == ST_STEP && i_step_done) || (run_was_q && !run_q)) begin
            addr_disp_q <= i_next_pc;
            data_disp_q <= i_next_instr;
        end else if (start_go && next_mode) begin
            addr_disp_q <= target;
        end else if (entry_ok && press_q[BTN_DCLR]) begin
            if (i_addr_sel) begin
                addr_disp_q <= '0;
            end else begin
                data_disp_q <= '0;
            end
        end else if (entry_ok) begin
            if (i_addr_sel) begin
                addr_disp_q <= addr_disp_q | i_sw_down;
            end else begin
                data_disp_q <= data_disp_q | i_sw_down;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            disp_q <= '0;
        end else if (run_like) begin
            disp_q <= i_addr_sel ? i_bma : ind_q;
        end else begin
            disp_q <= i_addr_sel ? addr_disp_q : data_disp_q;
        end
    end

    assign o_display = disp_q;

    // ************************************************************
    // Sense switches and programmed I/O
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sense_q    <= '0;
            ind_q      <= '0;
            io_rdata_q <= '0;
            io_ack_q   <= 1'b0;
        end else begin
            sense_q  <= i_sw_up;
            io_ack_q <= i_io.strobe;
            if (i_io.strobe && !i_io.is_input && i_io.dev == DEV_PANEL) begin
                ind_q <= i_io.wdata;
            end
            if (i_io.strobe && i_io.is_input) begin
                if (i_io.dev == DEV_SENSE) begin
                    io_rdata_q <= sense_q;
                end else if (i_io.dev == DEV_PANEL && mode_q == MODE_RUN) begin
                    io_rdata_q <= i_sw_down;
                end else begin
                    io_rdata_q <= '0;
                end
            end
        end
    end

    assign o_io_rdata = io_rdata_q;
    assign o_io_ack   = io_ack_q;
    assign o_sense_sw = sense_q;

    // ************************************************************
    // APB slave
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prdata_q    <= '0;
            perr_q      <= 1'b0;
            ctrl_lock_q <= 1'b0;
        end else begin
            if (psel && !penable) begin
                perr_q   <= 1'b0;
                prdata_q <= '0;
                case (paddr)
                    OFS_STATUS: prdata_q <= {22'h000000, i_key, 1'b0, mode_q,
                                             2'(st_q), run_q, !run_q};
                    OFS_CTRL:   prdata_q <= {31'h00000000, ctrl_lock_q};
                    OFS_ADDR:   prdata_q <= {16'h0000, addr_disp_q};
                    OFS_DATA:   prdata_q <= {16'h0000, data_disp_q};
                    OFS_SENSE:  prdata_q <= {16'h0000, sense_q};
                    default:    perr_q   <= 1'b1;
                endcase
            end
            if (psel && penable && pwrite && paddr == OFS_CTRL) begin
                ctrl_lock_q <= pwdata[CTRL_LOCK];
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = perr_q && psel && penable;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    sequence s_start_in(logic [2:0] m);
        start_go && mode_q == m;
    endsequence

    sequence s_incr_req;
        addr_disp_q == $past(addr_disp_q) + ADDR_STEP && o_acc_req;
    endsequence

    lock_mode_a: assert property (i_key == KEY_LOCK |=> $stable(mode_q))
        else $error("mode changed under lock");
    mclr_pulse_a: assert property (mclr_go |=> o_mclr ##1 !o_mclr)
        else $error("master clear pulse wrong");
    mclr_mode_a: assert property (o_mclr |-> !$past(run_like))
        else $error("master clear in run or load");
    run_view_a: assert property (run_like && i_addr_sel |=> o_display == $past(i_bma))
        else $error("run address view wrong");
    step_view_a: assert property (st_q == ST_STEP && i_step_done
        |=> addr_disp_q == $past(i_next_pc) && st_q == ST_IDLE)
        else $error("next PC not displayed");
    run_start_a: assert property (s_start_in(MODE_RUN) && !i_halt_instr
        |=> o_cpu_run)
        else $error("run did not start");
    xfer_block_a: assert property (mode_q == MODE_STOP |-> o_xfer_block ##1 !o_cpu_run)
        else $error("transfers open while stopped");
    store_keep_a: assert property (o_acc_req && o_acc.write && i_acc_ack
        |=> $stable(data_disp_q) && $stable(addr_disp_q))
        else $error("deposit altered display");
    fetch_next_a: assert property (s_start_in(MODE_FETCH_NEXT) |=> s_incr_req
        ##0 !o_acc.write)
        else $error("examine-next sequence wrong");
    store_next_a: assert property (s_start_in(MODE_STORE_NEXT) |=> s_incr_req
        ##0 o_acc.write)
        else $error("deposit-next sequence wrong");
    halt_lamp_a: assert property (o_halt_lamp == !o_cpu_run)
        else $error("halt lamp mismatch");
    dclr_zero_a: assert property (entry_ok && press_q[BTN_DCLR] && i_addr_sel
        && !(st_q == ST_STEP) |=> addr_disp_q == 16'h0000)
        else $error("data clear failed");
    sense_rd_a: assert property (i_io.strobe && i_io.is_input && i_io.dev == DEV_SENSE
        |=> o_io_ack && o_io_rdata == $past(sense_q))
        else $error("sense read wrong");
    one_press_a: assert property (press_q[BTN_START] |=> !press_q[BTN_START])
        else $error("start press repeated");

endmodule

// File: hdl/fpcc_pkg.sv
/*
 * Constants and carrier types for the front panel console controller.
 * Assumes a single 20 MHz core clock and switch inputs synchronous to it.
 */
package fpcc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned DEBOUNCE_US   = 5000;
    localparam int unsigned DEBOUNCE_CYC  = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    localparam int unsigned DEB_W         = 17;

    // ************************************************************
    // Switch codes
    // ************************************************************
    localparam logic [1:0] KEY_OFF        = 2'h0;
    localparam logic [1:0] KEY_ON         = 2'h1;
    localparam logic [1:0] KEY_LOCK       = 2'h2;

    localparam logic [2:0] MODE_LOAD       = 3'h0;
    localparam logic [2:0] MODE_RUN        = 3'h1;
    localparam logic [2:0] MODE_STOP       = 3'h2;
    localparam logic [2:0] MODE_STORE      = 3'h3;
    localparam logic [2:0] MODE_FETCH      = 3'h4;
    localparam logic [2:0] MODE_FETCH_NEXT = 3'h5;
    localparam logic [2:0] MODE_STORE_NEXT = 3'h6;

    // Button index in the debounced group
    localparam int BTN_START = 0;
    localparam int BTN_MCLR  = 1;
    localparam int BTN_DCLR  = 2;
    localparam int BTN_N     = 3;

    // Switch n sits at vector bit 16-n
    localparam int SW_SPACE  = 15;
    localparam int SW_SET    = 14;
    localparam int SW_HALF   = 12;

    // ************************************************************
    // Programmed I/O and master clear
    // ************************************************************
    localparam logic [9:0]  DEV_PANEL  = 10'h3D0;
    localparam logic [9:0]  DEV_SENSE  = 10'h390;
    localparam logic [15:0] MCLR_PC    = 16'h0200;
    localparam logic [15:0] ADDR_STEP  = 16'h0001;

    // ************************************************************
    // APB map
    // ************************************************************
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_CTRL   = 12'h004;
    localparam logic [11:0] OFS_ADDR   = 12'h008;
    localparam logic [11:0] OFS_DATA   = 12'h00C;
    localparam logic [11:0] OFS_SENSE  = 12'h010;
    localparam int          CTRL_LOCK  = 0;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic        write;
        logic        reg_space;
        logic        current_register_set;
        logic        half_hi;
        logic        mapped;
        logic [11:0] segment;
        logic [21:0] addr;
        logic [15:0] wdata;
    } fpcc_acc_t;

    typedef struct packed {
        logic        strobe;
        logic        is_input;
        logic [9:0]  dev;
        logic [15:0] wdata;
    } fpcc_io_t;

endpackage

// File: test/fpcc_cpu_model.sv
/* CPU side model: panel accesses answered after a wait, single step.
   Assumes the console holds its access request until acknowledged. */
`timescale 1ns/100ps
module fpcc_cpu_model (
    input  wire logic                i_core_clk, // Core clock
    input  wire logic                i_acc_req,  // Access request
    input  wire fpcc_pkg::fpcc_acc_t i_acc,      // Access descriptor
    input  wire logic                i_step,     // Step pulse
    output logic                     o_ack,      // Access done
    output logic [15:0]              o_rdata,    // Read data
    output logic                     o_done,     // Step done
    output logic [15:0]              o_pc,       // Next PC
    output logic [15:0]              o_instr     // Cell at next PC
);
    import fpcc_pkg::*;
    logic [15:0] mem_q [16];
    logic [1:0]  wt_q = 2'h0;
    initial begin
        for (int k = 0; k < 16; k++) mem_q[k] = 16'hA000 + 16'(k);
        {o_ack, o_done, o_pc, o_rdata} = '0;
    end
    assign o_instr = mem_q[o_pc[3:0]];
    always @(posedge i_core_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        o_done <= i_step;
        if (i_step) o_pc <= o_pc + 16'h0001;
        if (i_acc_req && !o_ack) wt_q <= wt_q + 2'h1;
        if (i_acc_req && !o_ack && wt_q == 2'h2) begin
            wt_q <= 2'h0;
            o_ack <= 1'b1;
            o_rdata <= mem_q[i_acc.addr[3:0]];
            if (i_acc.write) mem_q[i_acc.addr[3:0]] <= i_acc.wdata;
        end
    end
endmodule

// File: test/front_panel_console_controller_tb_top.sv
/* Self-checking bench: entry, access modes, step, run, I/O, lock, APB.
   Assumes the CPU model above on the far side. */
`timescale 1ns/100ps
module front_panel_console_controller_tb_top;
    import fpcc_pkg::*;
    typedef struct {logic [2:0] m; logic [15:0] a, d;} fpcc_row_t;
    fpcc_row_t rows [4] = '{'{MODE_STORE, 16'h0003, 16'h1234},
        '{MODE_FETCH_NEXT, 16'h0004, 16'hA004}, '{MODE_STORE_NEXT, 16'h0005, 16'hA004},
        '{MODE_FETCH, 16'h0005, 16'hA004}};
    logic clk = 1'b0, rst_n = 1'b0, asel = 1'b1, ps = 1'b0, pe = 1'b0, pw = 1'b0, er;
    logic halt, rdy, slverr, ack, done, step, req, run, mclr, xb, ioack;
    logic lg = 1'b0, halt_instruction = 1'b0, apl;
    logic [1:0] key = KEY_ON;
    logic [2:0] mode = MODE_STOP, btn = 3'h0;
    logic [11:0] pa = 12'h000;
    logic [15:0] up = 16'h0, down = 16'h0, disp, ard, pc, ins, iord, sense, mpc;
    logic [31:0] pwd = '0, prd, rd;
    fpcc_io_t io = '0;
    fpcc_acc_t acc;
    int err_count = 0, checks = 0, cyc_n = 0, mclr_n = 0;
    fpcc_console #(.DEB_CYCLES(4)) u_fpcc_console (.i_core_clk(clk), .i_arst_n(rst_n),
        .i_key(key), .i_mode(mode), .i_start_raw(btn[0]), .i_mclr_raw(btn[1]),
        .i_dclr_raw(btn[2]), .i_addr_sel(asel), .i_sw_up(up), .i_sw_down(down),
        .i_large_model(lg), .i_seg_enabled(lg), .i_bma(16'h0ABC), .i_halt_instr(halt_instruction),
        .i_step_done(done), .i_next_pc(pc), .i_next_instr(ins), .i_acc_ack(ack),
        .i_acc_rdata(ard), .i_io(io), .o_io_rdata(iord), .o_io_ack(ioack), .o_sense_sw(sense),
        .o_cpu_run(run), .o_step(step), .o_mclr(mclr), .o_mclr_pc(mpc), .o_xfer_block(xb),
        .o_apl_enable(apl), .o_acc_req(req), .o_acc(acc), .o_halt_lamp(halt), .o_display(disp),
        .psel(ps), .penable(pe), .pwrite(pw), .paddr(pa), .pwdata(pwd), .prdata(prd),
        .pready(rdy), .pslverr(slverr));
    fpcc_cpu_model u_fpcc_cpu_model (.i_core_clk(clk), .i_acc_req(req), .i_acc(acc),
        .i_step(step), .o_ack(ack), .o_rdata(ard), .o_done(done), .o_pc(pc), .o_instr(ins));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc_n++;
        if (mclr === 1'b1) mclr_n++;
        if (cyc_n == 4000) begin
            err_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic press(input int b);
        btn[b] <= 1'b1;
        cyc(6);
        btn[b] <= 1'b0;
        cyc(9);
    endtask
    task automatic ent(input logic [15:0] v);
        down <= v;
        cyc(2);
        down <= 16'h0;
        cyc(3);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        ps <= 1'b1;
        pw <= w;
        pa <= a;
        pwd <= d;
        cyc(1);
        pe <= 1'b1;
        do cyc(1); while (rdy !== 1'b1);
        rd = prd;
        er = slverr;
        ps <= 1'b0;
        pe <= 1'b0;
        cyc(1);
    endtask
    task automatic pio(input logic inp, input logic [9:0] dv, input logic [15:0] wd);
        io <= '{1'b1, inp, dv, wd};
        cyc(1);
        io.strobe <= 1'b0;
        cyc(3);
    endtask
    initial begin
        cyc(16);
        rst_n <= 1'b1;
        cyc(2);
        chk(halt, 1'b1);
        chk(xb, 1'b1);
        chk(mpc, 16'h0200);
        ent(16'h00F3);
        chk(disp, 16'h00F3);
        press(2);
        chk(disp, 16'h0000);
        ent(16'h0003);
        asel <= 1'b0;
        press(2);
        ent(16'h1234);
        foreach (rows[i]) begin
            mode <= rows[i].m;
            cyc(2);
            press(0);
            asel <= 1'b1;
            cyc(3);
            chk(disp, rows[i].a);
            asel <= 1'b0;
            cyc(3);
            chk(disp, rows[i].d);
        end
        $display("access rows done");
        mode <= MODE_STOP;
        cyc(2);
        press(0);
        chk(disp, 16'hA001);
        press(1);
        chk(mclr_n, 1);
        mode <= MODE_RUN;
        cyc(2);
        press(0);
        chk(run, 1'b1);
        chk(halt, 1'b0);
        chk(xb, 1'b0);
        press(1);
        chk(mclr_n, 1);
        pio(1'b0, DEV_PANEL, 16'hBEEF);
        chk(disp, 16'hBEEF);
        asel <= 1'b1;
        cyc(3);
        chk(disp, 16'h0ABC);
        up <= 16'h8001;
        down <= 16'h0040;
        cyc(2);
        pio(1'b1, DEV_SENSE, 16'h0);
        chk(iord, 16'h8001);
        chk(sense, 16'h8001);
        pio(1'b1, DEV_PANEL, 16'h0);
        chk(iord, 16'h0040);
        halt_instruction <= 1'b1;
        cyc(1);
        halt_instruction <= 1'b0;
        cyc(2);
        chk(halt, 1'b1);
        press(0);
        chk(run, 1'b1);
        down <= 16'h0;
        key <= KEY_LOCK;
        mode <= MODE_STOP;
        cyc(3);
        chk(run, 1'b1);
        key <= KEY_ON;
        cyc(3);
        chk(halt, 1'b1);
        $display("run and lock done");
        mode <= MODE_LOAD;
        cyc(2);
        chk(apl, 1'b1);
        lg <= 1'b1;
        up <= 16'hC005;
        mode <= MODE_FETCH;
        cyc(2);
        chk(apl, 1'b0);
        press(0);
        chk({acc.reg_space, acc.current_register_set, acc.addr}, {2'h2, 22'h000005});
        up <= 16'h9003;
        press(0);
        chk({acc.reg_space, acc.current_register_set, acc.half_hi, acc.addr}, {3'h7, 22'h000003});
        up <= 16'h1002;
        press(0);
        chk({acc.reg_space, acc.mapped, acc.addr}, {2'h0, 22'h020001});
        up <= 16'h0ABC;
        press(0);
        chk({acc.mapped, acc.segment}, {1'b1, 12'hABC});
        $display("addressing done");
        apb(1'b0, OFS_SENSE, '0);
        chk(rd, 32'h0ABC);
        apb(1'b0, 12'h040, '0);
        chk(er, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_CTRL, '0);
        chk(rd, 32'h1);
        $display("apb done");
        rst_n <= 1'b0;
        cyc(2);
        chk({halt, run, req, disp}, {3'h4, 16'h0000});
        rst_n <= 1'b1;
        cyc(2);
        apb(1'b0, OFS_CTRL, '0);
        chk(rd, 32'h0);
        $display("reset done");
        test_done();
    end
endmodule
